// ==== verilog/twr_consts.svh ====
// Constants shared by both ends of the three-wire register port
`ifndef TWR_CONSTS_SVH
`define TWR_CONSTS_SVH

// Frame layout
`define TWR_ADDR_W 4
`define TWR_DATA_W 8
`define TWR_NREG 16
`define TWR_FRAME_BITS 14
`define TWR_HEAD_BITS 5
`define TWR_LAST_DATA_EDGE 13

// Register bank reset value
`define TWR_REG_RST 8'h00

// Filtered input vector {select, clock, data}: bit positions and idle levels
`define TWR_IN_CSN 2
`define TWR_IN_SCLK 1
`define TWR_IN_SERIAL_DATA_IO 0
`define TWR_IN_RST 3'b101

// Timing
`define TWR_CLK_PERIOD_NS 25
`define TWR_SCLK_HALF_NS 500
`define TWR_HALF_CYC ((`TWR_SCLK_HALF_NS + `TWR_CLK_PERIOD_NS - 1) / `TWR_CLK_PERIOD_NS)
// Half period of a link clock made by the bench: 200 ns period at a 25 ns system clock
`define TWR_TB_SCLK_HALF 4

`endif

// ==== verilog/twr_pkg.sv ====
// Types shared by both ends of the three-wire register port
package twr_pkg;

	typedef enum logic [3:0] {
		D_IDLE = 4'b0001,
		D_HEAD = 4'b0010,
		D_WRITE = 4'b0100,
		D_READ = 4'b1000
	} twr_dev_st_t;

	typedef enum logic [5:0] {
		H_IDLE = 6'b000001,
		H_SETUP = 6'b000010,
		H_HIGH = 6'b000100,
		H_LOW = 6'b001000,
		H_TAIL = 6'b010000,
		H_GAP = 6'b100000
	} twr_host_st_t;

endpackage

// ==== verilog/twr_if.sv ====
// Three-wire link between host and device, with the shared data wire resolved
interface twr_if;
	logic chip_select_n;
	logic sclk;
	logic host_serial_data_io_o;
	logic host_serial_data_io_oe;
	logic dev_serial_data_io_o;
	logic dev_serial_data_io_oe;
	logic serial_data_io;

	// An undriven wire floats high, as with a pull-up
	assign serial_data_io = dev_serial_data_io_oe ? dev_serial_data_io_o : (host_serial_data_io_oe ? host_serial_data_io_o : 1'b1);

	modport dev_mp (
		input chip_select_n,
		input sclk,
		input serial_data_io,
		output dev_serial_data_io_o,
		output dev_serial_data_io_oe
	);

	modport host_mp (
		output chip_select_n,
		output sclk,
		output host_serial_data_io_o,
		output host_serial_data_io_oe,
		input serial_data_io
	);
endinterface

// ==== verilog/twr_host.sv ====
// Host end: makes select and serial clock, shifts out a frame, collects read data
`include "twr_consts.svh"

module twr_host (
	input wire logic CLOCK_I, // 40 MHz system clock
	input wire logic RESETN_I, // Synchronous reset, active low
	twr_if.host_mp LINK, // Serial link toward the device
	input wire logic START_I, // Pulse: begin a transaction
	input wire logic RW_I, // 1 read, 0 write
	input wire logic [`TWR_ADDR_W-1:0] ADDR_I, // Register address
	input wire logic [`TWR_DATA_W-1:0] WDATA_I, // Write data
	output logic BUSY_O, // High while a frame runs
	output logic DONE_O, // Pulse at end of frame
	output logic [`TWR_DATA_W-1:0] RDATA_O // Data of the last read
);
	twr_pkg::twr_host_st_t st_r, st_nxt;
	logic [4:0] tim_r, tim_nxt;
	logic [3:0] pcnt_r, pcnt_nxt;
	logic [`TWR_FRAME_BITS-1:0] tx_r, tx_nxt;
	logic [`TWR_DATA_W-1:0] rx_r, rx_nxt;
	logic rw_r, rw_nxt;
	logic csn_r, csn_nxt;
	logic sclk_r, sclk_nxt;
	logic oe_r, oe_nxt;
	logic busy_r, done_r;
	logic [`TWR_DATA_W-1:0] rdata_r;
	logic s1_r, s2_r, s3_r, sd_flt_r;
	logic tick;

	assign tick = (tim_r == 5'h00);

	// Read data arrives from another party, so it is filtered like a pin
	always_ff @(posedge CLOCK_I) begin
		if (!RESETN_I) begin
			s1_r <= 1'b1;
			s2_r <= 1'b1;
			s3_r <= 1'b1;
			sd_flt_r <= 1'b1;
		end else begin
			s1_r <= LINK.serial_data_io;
			s2_r <= s1_r;
			s3_r <= s2_r;
			sd_flt_r <= (s2_r == s3_r) ? s3_r : sd_flt_r;
		end
	end

	always_comb begin
		st_nxt = st_r;
		tim_nxt = tick ? 5'h00 : tim_r - 5'h01;
		pcnt_nxt = pcnt_r;
		tx_nxt = tx_r;
		rx_nxt = rx_r;
		rw_nxt = rw_r;
		csn_nxt = csn_r;
		sclk_nxt = sclk_r;
		oe_nxt = oe_r;
		case (st_r)
			twr_pkg::H_IDLE: begin
				if (START_I) begin
					st_nxt = twr_pkg::H_SETUP;
					tim_nxt = 5'(`TWR_HALF_CYC - 1);
					pcnt_nxt = 4'h0;
					tx_nxt = {RW_I, ADDR_I, 1'b0, WDATA_I};
					rw_nxt = RW_I;
					csn_nxt = 1'b0;
					oe_nxt = 1'b1;
				end
			end
			twr_pkg::H_SETUP, twr_pkg::H_LOW: begin
				if (tick) begin
					st_nxt = twr_pkg::H_HIGH;
					tim_nxt = 5'(`TWR_HALF_CYC - 1);
					sclk_nxt = 1'b1;
					pcnt_nxt = pcnt_r + 4'h1;
					if (rw_r && pcnt_r > 4'(`TWR_HEAD_BITS))
						rx_nxt = {rx_r[`TWR_DATA_W-2:0], sd_flt_r};
				end
			end
			twr_pkg::H_HIGH: begin
				if (tick) begin
					tim_nxt = 5'(`TWR_HALF_CYC - 1);
					sclk_nxt = 1'b0;
					tx_nxt = {tx_r[`TWR_FRAME_BITS-2:0], 1'b0};
					if (rw_r && pcnt_r == 4'(`TWR_HEAD_BITS))
						oe_nxt = 1'b0;
					st_nxt = (pcnt_r == 4'(`TWR_FRAME_BITS)) ? twr_pkg::H_TAIL : twr_pkg::H_LOW;
				end
			end
			twr_pkg::H_TAIL: begin
				if (tick) begin
					st_nxt = twr_pkg::H_GAP;
					tim_nxt = 5'(`TWR_HALF_CYC - 1);
					csn_nxt = 1'b1;
					oe_nxt = 1'b0;
				end
			end
			twr_pkg::H_GAP: begin
				if (tick)
					st_nxt = twr_pkg::H_IDLE;
			end
			default: begin
				st_nxt = twr_pkg::H_IDLE;
				csn_nxt = 1'b1;
				sclk_nxt = 1'b0;
				oe_nxt = 1'b0;
			end
		endcase
	end

	always_ff @(posedge CLOCK_I) begin
		if (!RESETN_I) begin
			st_r <= twr_pkg::H_IDLE;
			tim_r <= 5'h00;
			pcnt_r <= 4'h0;
			tx_r <= '0;
			rx_r <= '0;
			rw_r <= 1'b0;
			csn_r <= 1'b1;
			sclk_r <= 1'b0;
			oe_r <= 1'b0;
			busy_r <= 1'b0;
			done_r <= 1'b0;
			rdata_r <= '0;
		end else begin
			st_r <= st_nxt;
			tim_r <= tim_nxt;
			pcnt_r <= pcnt_nxt;
			tx_r <= tx_nxt;
			rx_r <= rx_nxt;
			rw_r <= rw_nxt;
			csn_r <= csn_nxt;
			sclk_r <= sclk_nxt;
			oe_r <= oe_nxt;
			busy_r <= (st_nxt != twr_pkg::H_IDLE);
			done_r <= (st_r == twr_pkg::H_GAP) && tick;
			if (st_r == twr_pkg::H_GAP && tick && rw_r)
				rdata_r <= rx_r;
		end
	end

	assign LINK.chip_select_n = csn_r;
	assign LINK.sclk = sclk_r;
	assign LINK.host_serial_data_io_o = tx_r[`TWR_FRAME_BITS-1];
	assign LINK.host_serial_data_io_oe = oe_r;
	assign BUSY_O = busy_r;
	assign DONE_O = done_r;
	assign RDATA_O = rdata_r;
endmodule // twr_host

// ==== verilog/twr_dev.sv ====
// Device end: filters the link pins, decodes frames and keeps the register bank
`include "twr_consts.svh"

// Notes on behaviour
// - Frame: flag, address, gap, data, MSB first
// - Flag low writes, flag high reads
// - Four address bits pick the register
// - Link active only while select is low
// - Write bits sampled on fourteen rising edges
// - Host holds data low in the gap
// - Read: flag and address on five rises
// - Read data driven on following falling edges
// - Host ignores the undefined gap slot
// - Host releases data while device drives
// - Host gives exactly fourteen clock pulses
// - Written value applied when select rises
module twr_dev (
	input wire logic CLOCK_I, // 40 MHz system clock
	input wire logic RESETN_I, // Synchronous reset, active low
	twr_if.dev_mp LINK, // Serial link toward the host
	output logic WR_STB_O, // Pulse: a register was written
	output logic [`TWR_ADDR_W-1:0] WR_ADDR_O, // Address of last write
	output logic [`TWR_DATA_W-1:0] WR_DATA_O, // Data of last write
	output logic FRAME_ERR_O, // Pulse: frame ended with a bad edge count
	output logic [`TWR_NREG*`TWR_DATA_W-1:0] REGS_O // Register bank, entry 0 lowest
);
	// Input filter: three stages, a change is taken once stages two and three agree
	logic [2:0] in_raw;
	logic [2:0] s1_r, s2_r, s3_r;
	logic [2:0] flt_r, flt_d_r;
	logic [2:0] flt_nxt;

	assign in_raw = {LINK.chip_select_n, LINK.sclk, LINK.serial_data_io};
	assign flt_nxt = (~(s2_r ^ s3_r) & s3_r) | ((s2_r ^ s3_r) & flt_r);

	always_ff @(posedge CLOCK_I) begin
		if (!RESETN_I) begin
			s1_r <= `TWR_IN_RST;
			s2_r <= `TWR_IN_RST;
			s3_r <= `TWR_IN_RST;
			flt_r <= `TWR_IN_RST;
			flt_d_r <= `TWR_IN_RST;
		end else begin
			s1_r <= in_raw;
			s2_r <= s1_r;
			s3_r <= s2_r;
			flt_r <= flt_nxt;
			flt_d_r <= flt_r;
		end
	end

	// Edge detection on filtered levels; clock edges count only under select
	wire csn_low;
	wire sclk_rise;
	wire sclk_fall;
	wire csn_rise;
	wire sd_in;

	assign csn_low = ~flt_r[`TWR_IN_CSN];
	assign sclk_rise = csn_low & flt_r[`TWR_IN_SCLK] & ~flt_d_r[`TWR_IN_SCLK];
	assign sclk_fall = csn_low & ~flt_r[`TWR_IN_SCLK] & flt_d_r[`TWR_IN_SCLK];
	assign csn_rise = flt_r[`TWR_IN_CSN] & ~flt_d_r[`TWR_IN_CSN];
	assign sd_in = flt_r[`TWR_IN_SERIAL_DATA_IO];

	// Rising-edge count and input shift register
	logic [3:0] cnt_r, cnt_nxt;
	logic [`TWR_FRAME_BITS-1:0] sh_r, sh_nxt;

	// Count saturates so a runaway clock cannot wrap back to a valid count
	assign cnt_nxt = !csn_low ? 4'h0 :
		(sclk_rise && cnt_r != 4'hf) ? cnt_r + 4'h1 : cnt_r;
	assign sh_nxt = sclk_rise ? {sh_r[`TWR_FRAME_BITS-2:0], sd_in} : sh_r;

	// Field views: after five rises the header sits in the low bits,
	// after fourteen the whole frame fills the register
	wire head_rw;
	wire [`TWR_ADDR_W-1:0] head_addr;
	wire frm_rw;
	wire [`TWR_ADDR_W-1:0] frm_addr;
	wire [`TWR_DATA_W-1:0] frm_data;

	assign head_rw = sh_r[`TWR_HEAD_BITS-1];
	assign head_addr = sh_r[`TWR_ADDR_W-1:0];
	assign frm_rw = sh_r[`TWR_FRAME_BITS-1];
	assign frm_addr = sh_r[`TWR_FRAME_BITS-2 -: `TWR_ADDR_W];
	assign frm_data = sh_r[`TWR_DATA_W-1:0];

	// Frame state
	twr_pkg::twr_dev_st_t st_r, st_nxt;
	wire head_done;

	assign head_done = sclk_fall && (cnt_r == 4'(`TWR_HEAD_BITS));

	always_comb begin
		st_nxt = st_r;
		case (st_r)
			twr_pkg::D_IDLE: begin
				if (csn_low)
					st_nxt = twr_pkg::D_HEAD;
			end
			twr_pkg::D_HEAD: begin
				if (!csn_low)
					st_nxt = twr_pkg::D_IDLE;
				else if (head_done)
					st_nxt = head_rw ? twr_pkg::D_READ : twr_pkg::D_WRITE;
			end
			twr_pkg::D_WRITE, twr_pkg::D_READ: begin
				if (!csn_low)
					st_nxt = twr_pkg::D_IDLE;
			end
			default: begin
				st_nxt = twr_pkg::D_IDLE;
			end
		endcase
	end

	// Register bank
	logic [`TWR_DATA_W-1:0] regs_r [`TWR_NREG];
	wire commit_ok;
	wire frame_bad;

	// A frame with a wrong edge count is dropped rather than half applied
	assign commit_ok = csn_rise && (st_r == twr_pkg::D_WRITE) && !frm_rw &&
		(cnt_r == 4'(`TWR_FRAME_BITS));
	assign frame_bad = csn_rise && (cnt_r != 4'h0) && (cnt_r != 4'(`TWR_FRAME_BITS));

	genvar gi;
	generate
		for (gi = 0; gi < `TWR_NREG; gi++) begin : g_reg
			always_ff @(posedge CLOCK_I) begin
				if (!RESETN_I)
					regs_r[gi] <= `TWR_REG_RST;
				else if (commit_ok && frm_addr == 4'(gi))
					regs_r[gi] <= frm_data;
			end
			assign REGS_O[gi*`TWR_DATA_W +: `TWR_DATA_W] = regs_r[gi];
		end
	endgenerate

	// Read output path
	logic [`TWR_DATA_W-1:0] rd_byte_r, rd_byte_nxt;
	logic out_r, out_nxt;
	logic oe_r, oe_nxt;
	wire start_rd;
	wire shift_out;
	wire [2:0] rd_idx;
	wire [`TWR_DATA_W-1:0] sel_byte;

	assign start_rd = head_done && head_rw && (st_r == twr_pkg::D_HEAD);
	assign shift_out = sclk_fall && (st_r == twr_pkg::D_READ) &&
		(cnt_r > 4'(`TWR_HEAD_BITS)) && (cnt_r <= 4'(`TWR_LAST_DATA_EDGE));
	assign rd_idx = 3'(4'(`TWR_LAST_DATA_EDGE) - cnt_r);
	assign sel_byte = regs_r[head_addr];
	assign rd_byte_nxt = start_rd ? sel_byte : rd_byte_r;
	// The gap slot already carries the top data bit; the host does not use it
	assign out_nxt = start_rd ? sel_byte[`TWR_DATA_W-1] :
		(shift_out ? rd_byte_r[rd_idx] : out_r);
	assign oe_nxt = csn_low && (start_rd || oe_r);

	always_ff @(posedge CLOCK_I) begin
		if (!RESETN_I) begin
			cnt_r <= 4'h0;
			sh_r <= '0;
			st_r <= twr_pkg::D_IDLE;
			rd_byte_r <= '0;
			out_r <= 1'b0;
			oe_r <= 1'b0;
		end else begin
			cnt_r <= cnt_nxt;
			sh_r <= sh_nxt;
			st_r <= st_nxt;
			rd_byte_r <= rd_byte_nxt;
			out_r <= out_nxt;
			oe_r <= oe_nxt;
		end
	end

	// User-side write report
	logic wr_stb_r;
	logic [`TWR_ADDR_W-1:0] wr_addr_r;
	logic [`TWR_DATA_W-1:0] wr_data_r;
	logic frame_err_r;

	always_ff @(posedge CLOCK_I) begin
		if (!RESETN_I) begin
			wr_stb_r <= 1'b0;
			wr_addr_r <= '0;
			wr_data_r <= '0;
			frame_err_r <= 1'b0;
		end else begin
			wr_stb_r <= commit_ok;
			frame_err_r <= frame_bad;
			if (commit_ok) begin
				wr_addr_r <= frm_addr;
				wr_data_r <= frm_data;
			end
		end
	end

	assign LINK.dev_serial_data_io_o = out_r;
	assign LINK.dev_serial_data_io_oe = oe_r;
	assign WR_STB_O = wr_stb_r;
	assign WR_ADDR_O = wr_addr_r;
	assign WR_DATA_O = wr_data_r;
	assign FRAME_ERR_O = frame_err_r;
endmodule // twr_dev

// ==== tb/twr_link_props.sv ====
// Assertions on the link between the host and device ends
module twr_link_props (
	input wire logic CLOCK_I, // System clock
	input wire logic RESETN_I, // Sync reset, active low
	input wire logic chip_select_n, // Select
	input wire logic sclk, // Serial clock
	input wire logic host_serial_data_io_o, // Host data
	input wire logic host_serial_data_io_oe, // Host drives wire
	input wire logic dev_serial_data_io_o, // Device data
	input wire logic dev_serial_data_io_oe, // Device drives wire
	input wire logic serial_data_io // Resolved wire
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [3:0] cnt_r;
	logic sclk_r;
	logic rd_r;
	wire rise = sclk & ~sclk_r;
	// Counts raw rises per frame; saturates so over-long frames stay visible
	always_ff @(posedge CLOCK_I) begin
		sclk_r <= sclk;
		if (!RESETN_I || chip_select_n)
			cnt_r <= 4'h0;
		else if (rise && cnt_r != 4'hf)
			cnt_r <= cnt_r + 4'h1;
		if (rise && cnt_r == 4'h0)
			rd_r <= serial_data_io;
	end
	default clocking cb @(posedge CLOCK_I);
	endclocking
	default disable iff (!RESETN_I);
	sclk_idle_a: assert property (chip_select_n |-> !sclk)
		else $error("serial clock high while deselected");
	idle_quiet_a: assert property (chip_select_n [*8] |-> !dev_serial_data_io_oe)
		else $error("device drives while deselected");
	oe_release_a: assert property ($rose(chip_select_n) |-> ##[1:8] !dev_serial_data_io_oe)
		else $error("device late releasing wire");
	frame_count_a: assert property ($rose(chip_select_n) |-> cnt_r == 4'he)
		else $error("frame without fourteen clock rises");
	no_clash_a: assert property (!(dev_serial_data_io_oe && host_serial_data_io_oe))
		else $error("both ends drive the wire");
	write_quiet_a: assert property (cnt_r != 4'h0 && !rd_r |-> !dev_serial_data_io_oe)
		else $error("device drives during a write");
	gap_low_a: assert property ($rose(sclk) && cnt_r == 4'h5 && !rd_r |-> !serial_data_io)
		else $error("gap bit not low on write");
	read_drive_a: assert property ($fell(sclk) && cnt_r == 4'h5 && rd_r
		|-> ##[1:12] dev_serial_data_io_oe)
		else $error("device did not drive read data");
	read_start_a: assert property ($rose(dev_serial_data_io_oe) |-> rd_r && cnt_r == 4'h5)
		else $error("device drove outside read window");
	data_hold_a: assert property (dev_serial_data_io_oe && sclk && $past(sclk)
		|-> $stable(dev_serial_data_io_o))
		else $error("read bit changed while clock high");
	rd_c: cover property ($fell(sclk) && cnt_r == 4'h5 && rd_r);
	wr_c: cover property ($rose(chip_select_n) && !rd_r);
	gap_c: cover property ($rose(sclk) && cnt_r == 4'h5 && !rd_r);
endmodule // twr_link_props

// ==== tb/tb_three_wire_register_port.sv ====
// Testbench joining host and device ends, plus a device fed by hand-driven frames of 13, 15 and 14 clock pulses
`include "twr_consts.svh"
module tb_three_wire_register_port;
	timeunit 1ns;
	timeprecision 1ps;
	typedef struct packed {logic rw; logic [3:0] a; logic [7:0] d;} twr_row_t;
	logic clk = 1'b0;
	logic rstn = 1'b0;
	logic start = 1'b0;
	twr_row_t req = '0;
	logic busy, done, stb, ferr, stb2, ferr2;
	logic [3:0] wa;
	logic [7:0] wdo, rdat;
	logic [127:0] regs, regs2;
	logic [7:0] exp_mem [16] = '{default: 8'h00};
	int mismatches = 0;
	int check_count = 0;
	int stb_n = 0;
	int e1 = 0;
	int e2 = 0;
	int s2 = 0;
	twr_row_t rows [8] = '{'{1'b0, 4'h0, 8'ha5}, '{1'b0, 4'hf, 8'h3c},
		'{1'b0, 4'h8, 8'h81}, '{1'b0, 4'h8, 8'h7e}, '{1'b1, 4'h0, 8'ha5},
		'{1'b1, 4'hf, 8'h3c}, '{1'b1, 4'h8, 8'h7e}, '{1'b1, 4'h3, 8'h00}};
	twr_if link();
	twr_if link2();
	twr_host i_twr_host(.CLOCK_I(clk), .RESETN_I(rstn), .LINK(link), .START_I(start),
		.RW_I(req.rw), .ADDR_I(req.a), .WDATA_I(req.d), .BUSY_O(busy), .DONE_O(done),
		.RDATA_O(rdat));
	twr_dev i_twr_dev(.CLOCK_I(clk), .RESETN_I(rstn), .LINK(link), .WR_STB_O(stb),
		.WR_ADDR_O(wa), .WR_DATA_O(wdo), .FRAME_ERR_O(ferr), .REGS_O(regs));
	twr_dev i_twr_dev_bad(.CLOCK_I(clk), .RESETN_I(rstn), .LINK(link2), .WR_STB_O(stb2),
		.WR_ADDR_O(), .WR_DATA_O(), .FRAME_ERR_O(ferr2), .REGS_O(regs2));
	twr_link_props i_twr_link_props(.CLOCK_I(clk), .RESETN_I(rstn), .chip_select_n(link.chip_select_n),
		.sclk(link.sclk), .host_serial_data_io_o(link.host_serial_data_io_o), .host_serial_data_io_oe(link.host_serial_data_io_oe),
		.dev_serial_data_io_o(link.dev_serial_data_io_o), .dev_serial_data_io_oe(link.dev_serial_data_io_oe), .serial_data_io(link.serial_data_io));
	initial forever #12.5 clk = ~clk;
	always @(posedge clk) begin
		stb_n += (stb === 1'b1);
		e1 += (ferr === 1'b1);
		e2 += (ferr2 === 1'b1);
		s2 += (stb2 === 1'b1);
	end
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		check_count++;
		if (got !== exp) begin
			mismatches++;
			$display("CHECK FAILED t=%0t got %h exp %h", $time, got, exp);
		end
	endtask
	task automatic tick(input int n);
		repeat (n) @(posedge clk);
	endtask
	task automatic complete_run;
		$display("checks %0d mismatches %0d", check_count, mismatches);
		if (mismatches == 0 && check_count > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask
	task automatic xfer(input twr_row_t r);
		int n;
		n = 0;
		start <= 1'b1;
		req <= r;
		@(posedge clk);
		start <= 1'b0;
		@(posedge clk);
		chk(16'({busy, link.chip_select_n}), 16'h0002);
		if (!r.rw) begin
			@(posedge link.chip_select_n);
			chk(16'(regs[8*r.a +: 8]), 16'(exp_mem[r.a]));
			exp_mem[r.a] = r.d;
		end
		while (done !== 1'b1 && n < 2000) begin
			@(posedge clk);
			n++;
		end
		// A frame that never finishes counts as a mismatch
		chk(16'(done === 1'b1), 16'h0001);
	endtask
	// Hand-driven write frame to address 2 with a chosen number of clock pulses
	task automatic bad(input int n);
		logic [13:0] f;
		f = {1'b0, 4'h2, 1'b0, 8'h55};
		link2.chip_select_n <= 1'b0;
		link2.host_serial_data_io_oe <= 1'b1;
		for (int i = 0; i < n; i++) begin
			link2.host_serial_data_io_o <= (i < 14) ? f[13-i] : 1'b0;
			tick(`TWR_TB_SCLK_HALF);
			link2.sclk <= 1'b1;
			tick(`TWR_TB_SCLK_HALF);
			link2.sclk <= 1'b0;
		end
		tick(`TWR_TB_SCLK_HALF);
		link2.chip_select_n <= 1'b1;
		link2.host_serial_data_io_oe <= 1'b0;
		tick(40);
	endtask
	initial begin
		link2.chip_select_n = 1'b1;
		link2.sclk = 1'b0;
		link2.host_serial_data_io_o = 1'b0;
		link2.host_serial_data_io_oe = 1'b0;
		tick(5);
		rstn <= 1'b1;
		tick(2);
		chk(16'({link.chip_select_n, link.sclk, link.dev_serial_data_io_oe, busy, done}), 16'h0010);
		chk(16'(regs !== '0), 16'h0000);
		foreach (rows[i]) begin
			xfer(rows[i]);
			if (rows[i].rw)
				chk(16'(rdat), 16'(rows[i].d));
			else
				chk(16'({wa, wdo}), 16'({rows[i].a, rows[i].d}));
		end
		chk(16'(stb_n), 16'h0004);
		chk(16'(e1), 16'h0000);
		bad(13);
		chk(16'(s2), 16'h0000);
		bad(15);
		chk({s2[7:0], e2[7:0]}, 16'h0002);
		bad(14);
		chk({s2[7:0], regs2[23:16]}, 16'h0155);
		// Reset in mid-run, with written registers and a read value held
		rstn <= 1'b0;
		tick(5);
		rstn <= 1'b1;
		tick(2);
		chk(16'({link.chip_select_n, link.dev_serial_data_io_oe, busy, rdat}), 16'h0400);
		chk(16'({regs !== '0, regs2 !== '0}), 16'h0000);
		complete_run;
	end
	initial begin
		tick(12000);
		mismatches++;
		complete_run;
	end
endmodule // tb_three_wire_register_port
